// file: rtl/rmrw_record_writer.sv
// Receive subaddress record writer: collects message flags and writes the record to RAM.
// Assumes the decoder gives one strobe per word, a command start and an end-of-message pulse,
// and that the shared RAM takes a write on every cycle that RAM_WR_EN is high.
`timescale 1ns/1ps

module rmrw_record_writer (
   // Clock and reset
   input  wire logic                          CORE_CLK,
   input  wire logic                          RST,
   // Configuration
   input  wire logic                          DEFER_DATA_WRITE,
   input  wire logic                          GAP_OR_BCAST_SELECT,
   // Command start
   input  wire logic                          CMD_VALID,
   input  wire logic [rmrw_pkg::WC_W-1:0]     CMD_WORD_COUNT,
   input  wire logic                          CMD_BUS_B,
   input  wire logic                          CMD_BROADCAST,
   input  wire logic                          CMD_RT_RT,
   input  wire logic                          CMD_ILLEGAL,
   input  wire logic                          CMD_GLOBAL_BUSY,
   input  wire logic                          CMD_PER_COMMAND_BUSY,
   input  wire logic [rmrw_pkg::ADDR_W-1:0]   CMD_DATA_POINTER,
   input  wire logic [rmrw_pkg::DATA_W-1:0]   CMD_TIME_TAG,
   // Received words and message events
   input  wire logic                          WORD_VALID,
   input  wire logic [rmrw_pkg::DATA_W-1:0]   WORD_DATA,
   input  wire logic                          WORD_MANCHESTER_ERR,
   input  wire logic                          WORD_PARITY_ERR,
   input  wire logic                          WORD_CMD_SYNC,
   input  wire logic                          RESP_TIMEOUT,
   input  wire logic                          GAP_DETECTED,
   input  wire logic                          SENDER_FAULT,
   input  wire logic                          MSG_DONE,
   // Shared RAM write port
   output logic                               RAM_WR_EN,
   output logic      [rmrw_pkg::ADDR_W-1:0]   RAM_WR_ADDR,
   output logic      [rmrw_pkg::DATA_W-1:0]   RAM_WR_DATA,
   // Status
   output logic                               RECORD_BUSY,
   output logic                               RECORD_DONE,
   output logic      [rmrw_pkg::DATA_W-1:0]   LAST_INFO_WORD
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   rmrw_pkg::rmrw_state_e state_reg;
   rmrw_pkg::rmrw_state_e state_next;
   logic                             defer_reg;
   logic                             gapsel_reg;
   logic [rmrw_pkg::WC_W-1:0]        wc_reg;
   logic                             busb_reg;
   logic                             bcast_reg;
   logic                             terminal_to_terminal_flag_reg;
   logic                             illegal_reg;
   logic                             busy_reg;
   logic [rmrw_pkg::ADDR_W-1:0]      ptr_reg;
   logic [rmrw_pkg::DATA_W-1:0]      tag_reg;
   logic [rmrw_pkg::CNT_W-1:0]       word_cnt_reg;
   logic [rmrw_pkg::CNT_W-1:0]       rd_idx_reg;
   logic [rmrw_pkg::CNT_W-1:0]       pend_idx_reg;
   logic                             pend_reg;
   logic [rmrw_pkg::NUM_FLAGS-1:0]   flags_reg;
   logic [rmrw_pkg::NUM_FLAGS-1:0]   flag_set;
   logic [rmrw_pkg::DATA_W-1:0]      info_word;
   logic [rmrw_pkg::DATA_W-1:0]      buf_rdata;
   logic [rmrw_pkg::CNT_W-1:0]       expected;
   logic [rmrw_pkg::ADDR_W-1:0]      live_addr;
   logic [rmrw_pkg::ADDR_W-1:0]      flush_addr;
   logic                             start;
   logic                             in_rx;
   logic                             word_bad;
   logic                             word_ok;
   logic                             err_live;
   logic                             short_cnt;
   logic                             message_error_flag;
   logic                             store_word;
   logic                             issue;
   logic                             we_next;
   logic [rmrw_pkg::ADDR_W-1:0]      addr_next;
   logic [rmrw_pkg::DATA_W-1:0]      data_next;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode of the current word and message state
   assign start      = (state_reg == rmrw_pkg::RMRW_IDLE) && CMD_VALID;
   assign in_rx      = (state_reg == rmrw_pkg::RMRW_RECEIVE);
   assign expected   = (wc_reg == rmrw_pkg::WC_ZERO) ? rmrw_pkg::FULL_COUNT : {1'b0, wc_reg};
   assign word_bad   = WORD_MANCHESTER_ERR || WORD_PARITY_ERR;
   assign word_ok    = WORD_VALID && !word_bad && !WORD_CMD_SYNC;
   assign err_live   = |flags_reg;
   assign short_cnt  = word_cnt_reg < expected;
   assign message_error_flag       = err_live || short_cnt;
   // Once an error is seen, immediate mode stops writing; deferred mode discards later anyway
   assign store_word = in_rx && word_ok && short_cnt && (defer_reg || !err_live);
   assign issue      = (state_reg == rmrw_pkg::RMRW_FLUSH) && (rd_idx_reg < word_cnt_reg);

   // Event sources of the sticky error flags
   // Time-out only for RT-RT
   assign flag_set[rmrw_pkg::FLG_TIMEOUT] = RESP_TIMEOUT && terminal_to_terminal_flag_reg;
   assign flag_set[rmrw_pkg::FLG_BADWORD] = WORD_VALID && word_bad;
   assign flag_set[rmrw_pkg::FLG_SYNC]    = WORD_VALID && WORD_CMD_SYNC;
   assign flag_set[rmrw_pkg::FLG_GAP]     = GAP_DETECTED;
   assign flag_set[rmrw_pkg::FLG_SENDER]  = SENDER_FAULT;

   ////////////////////////////////////////////////////////////////////////////////
   // Info word assembly from the latched command and flags
   assign info_word[rmrw_pkg::BIT_TIMEOUT] = flags_reg[rmrw_pkg::FLG_TIMEOUT];
   assign info_word[rmrw_pkg::BIT_BADWORD] = flags_reg[rmrw_pkg::FLG_BADWORD];
   assign info_word[rmrw_pkg::BIT_GAPBC]   = gapsel_reg ? bcast_reg : flags_reg[rmrw_pkg::FLG_GAP];
   assign info_word[rmrw_pkg::BIT_SHORT]   = short_cnt;
   assign info_word[rmrw_pkg::BIT_SYNC]    = flags_reg[rmrw_pkg::FLG_SYNC];
   assign info_word[rmrw_pkg::BIT_MESSAGE_ERROR_FLAG]    = message_error_flag;
   assign info_word[rmrw_pkg::BIT_BUSY]    = busy_reg;
   assign info_word[rmrw_pkg::BIT_ILLEGAL] = illegal_reg;
   assign info_word[rmrw_pkg::BIT_SENDER]  = flags_reg[rmrw_pkg::FLG_SENDER];
   assign info_word[rmrw_pkg::BIT_TERMINAL_TO_TERMINAL_FLAG]    = terminal_to_terminal_flag_reg && !message_error_flag;
   assign info_word[rmrw_pkg::BIT_BUS]     = busb_reg;
   assign info_word[rmrw_pkg::BIT_WC_MSB:rmrw_pkg::BIT_WC_LSB] = wc_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Record sequencing
   // Error skips data flush
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         rmrw_pkg::RMRW_IDLE:    if (CMD_VALID) state_next = rmrw_pkg::RMRW_RECEIVE;
         rmrw_pkg::RMRW_RECEIVE: if (MSG_DONE) state_next = rmrw_pkg::RMRW_CLOSE;
         rmrw_pkg::RMRW_CLOSE:   state_next = (defer_reg && !message_error_flag) ? rmrw_pkg::RMRW_FLUSH
                                                                   : rmrw_pkg::RMRW_TAG;
         rmrw_pkg::RMRW_FLUSH:   if (!issue) state_next = rmrw_pkg::RMRW_TAG;
         rmrw_pkg::RMRW_TAG:     state_next = rmrw_pkg::RMRW_INFO;
         rmrw_pkg::RMRW_INFO:    state_next = rmrw_pkg::RMRW_IDLE;
         default:                state_next = rmrw_pkg::RMRW_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) state_reg <= rmrw_pkg::RMRW_IDLE;
      else     state_reg <= state_next;
   end

   // Command context, taken once so a mid-message change of configuration cannot split a record
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         {defer_reg, gapsel_reg, busb_reg, bcast_reg, terminal_to_terminal_flag_reg, illegal_reg, busy_reg} <= 7'h00;
         wc_reg  <= rmrw_pkg::WC_ZERO;
         ptr_reg <= '0;
         tag_reg <= '0;
      end else if (start) begin
         {defer_reg, gapsel_reg} <= {DEFER_DATA_WRITE, GAP_OR_BCAST_SELECT};
         {busb_reg, bcast_reg, terminal_to_terminal_flag_reg} <= {CMD_BUS_B, CMD_BROADCAST, CMD_RT_RT};
         illegal_reg <= CMD_ILLEGAL;
         busy_reg    <= CMD_GLOBAL_BUSY || CMD_PER_COMMAND_BUSY;
         wc_reg      <= CMD_WORD_COUNT;
         ptr_reg     <= CMD_DATA_POINTER;
         tag_reg     <= CMD_TIME_TAG;
      end
   end

   // Sticky error flags, cleared only by reset and at the start of the next record
   genvar g;
   generate
      for (g = 0; g < rmrw_pkg::NUM_FLAGS; g = g + 1) begin : g_flag
         always_ff @(posedge CORE_CLK) begin
            if (RST || start)             flags_reg[g] <= 1'b0;
            else if (in_rx && flag_set[g]) flags_reg[g] <= 1'b1;
         end
      end
   endgenerate

   // Word counting; words beyond the expected count are never written
   always_ff @(posedge CORE_CLK) begin
      if (RST || start)                             word_cnt_reg <= '0;
      else if (in_rx && WORD_VALID && short_cnt)    word_cnt_reg <= word_cnt_reg + rmrw_pkg::CNT_ONE;
   end

   // Flush read pointer; buffer read data land one cycle after the issue
   always_ff @(posedge CORE_CLK) begin
      if (RST || start) begin
         rd_idx_reg   <= '0;
         pend_idx_reg <= '0;
         pend_reg     <= 1'b0;
      end else begin
         pend_reg     <= issue;
         pend_idx_reg <= rd_idx_reg;
         if (issue) rd_idx_reg <= rd_idx_reg + rmrw_pkg::CNT_ONE;
      end
   end

   rmrw_word_buf u_word_buf (
      .core_clk (CORE_CLK),
      .wr_en    (store_word && defer_reg),
      .wr_addr  (word_cnt_reg[rmrw_pkg::BUF_AW-1:0]),
      .wr_data  (WORD_DATA),
      .rd_addr  (rd_idx_reg[rmrw_pkg::BUF_AW-1:0]),
      .rd_data  (buf_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // RAM write selection
   // Data after the two header words
   assign live_addr  = ptr_reg + rmrw_pkg::DATA_OFFSET
                     + {{(rmrw_pkg::ADDR_W-rmrw_pkg::CNT_W){1'b0}}, word_cnt_reg};
   assign flush_addr = ptr_reg + rmrw_pkg::DATA_OFFSET
                     + {{(rmrw_pkg::ADDR_W-rmrw_pkg::CNT_W){1'b0}}, pend_idx_reg};
   assign we_next    = (store_word && !defer_reg) || pend_reg
                     || (state_reg == rmrw_pkg::RMRW_TAG) || (state_reg == rmrw_pkg::RMRW_INFO);
   // Tag at pointer plus one, info at pointer, info last so the host sees a full record
   assign addr_next  = (state_reg == rmrw_pkg::RMRW_INFO) ? ptr_reg
                     : (state_reg == rmrw_pkg::RMRW_TAG)  ? ptr_reg + rmrw_pkg::TAG_OFFSET
                     : pend_reg ? flush_addr : live_addr;
   assign data_next  = (state_reg == rmrw_pkg::RMRW_INFO) ? info_word
                     : (state_reg == rmrw_pkg::RMRW_TAG)  ? tag_reg
                     : pend_reg ? buf_rdata : WORD_DATA;

   // Registered RAM port and status
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         RAM_WR_EN      <= 1'b0;
         RAM_WR_ADDR    <= '0;
         RAM_WR_DATA    <= '0;
         RECORD_DONE    <= 1'b0;
         LAST_INFO_WORD <= rmrw_pkg::INFO_RESET;
      end else begin
         RAM_WR_EN   <= we_next;
         RAM_WR_ADDR <= addr_next;
         RAM_WR_DATA <= data_next;
         RECORD_DONE <= (state_reg == rmrw_pkg::RMRW_INFO);
         if (state_reg == rmrw_pkg::RMRW_INFO) LAST_INFO_WORD <= info_word;
      end
   end

   assign RECORD_BUSY = (state_reg != rmrw_pkg::RMRW_IDLE);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   // Tag placement
   a_tag_word_place: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == rmrw_pkg::RMRW_TAG) |=> RAM_WR_EN && RAM_WR_DATA == tag_reg
         && RAM_WR_ADDR == ptr_reg + rmrw_pkg::TAG_OFFSET ##1 RAM_WR_EN && RAM_WR_ADDR == ptr_reg)
      else $error("tag or info word misplaced");
   a_error_no_data: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == rmrw_pkg::RMRW_CLOSE && message_error_flag) |=> state_reg == rmrw_pkg::RMRW_TAG ##1 !pend_reg)
      else $error("data flushed for errored record");
   a_defer_hold_data: assert property (@(posedge CORE_CLK) disable iff (RST)
      (in_rx && defer_reg) |=> !RAM_WR_EN)
      else $error("RAM written during deferred receive");
   a_immed_word_write: assert property (@(posedge CORE_CLK) disable iff (RST)
      (store_word && !defer_reg) |=> RAM_WR_EN && RAM_WR_DATA == $past(WORD_DATA)
         && RAM_WR_ADDR == $past(live_addr))
      else $error("received word not written at once");
   a_timeout_bit_set: assert property (@(posedge CORE_CLK) disable iff (RST)
      (in_rx && RESP_TIMEOUT && terminal_to_terminal_flag_reg) |=> info_word[rmrw_pkg::BIT_TIMEOUT]
         && info_word[rmrw_pkg::BIT_MESSAGE_ERROR_FLAG])
      else $error("time-out not flagged");
   a_bad_word_bit: assert property (@(posedge CORE_CLK) disable iff (RST)
      (in_rx && WORD_VALID && word_bad) |=> info_word[rmrw_pkg::BIT_BADWORD] && !RAM_WR_EN)
      else $error("bad word not flagged or written");
   a_gap_flag_shown: assert property (@(posedge CORE_CLK) disable iff (RST)
      (in_rx && GAP_DETECTED && !gapsel_reg) |=> info_word[rmrw_pkg::BIT_GAPBC])
      else $error("gap error not flagged");
   a_short_count_bit: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == rmrw_pkg::RMRW_CLOSE && word_cnt_reg == expected)
         |-> !info_word[rmrw_pkg::BIT_SHORT])
      else $error("short count flagged on full message");
   a_sync_error_bit: assert property (@(posedge CORE_CLK) disable iff (RST)
      (in_rx && WORD_VALID && WORD_CMD_SYNC) |=> info_word[rmrw_pkg::BIT_SYNC])
      else $error("sync error not flagged");
   a_terminal_to_terminal_flag_clean_only: assert property (@(posedge CORE_CLK) disable iff (RST)
      info_word[rmrw_pkg::BIT_TERMINAL_TO_TERMINAL_FLAG] |-> !info_word[rmrw_pkg::BIT_SENDER]
         && !info_word[rmrw_pkg::BIT_MESSAGE_ERROR_FLAG])
      else $error("RT-RT flag with error");
   a_count_bus_copy: assert property (@(posedge CORE_CLK) disable iff (RST)
      start |=> info_word[rmrw_pkg::BIT_WC_MSB:0] == $past(CMD_WORD_COUNT)
         && info_word[rmrw_pkg::BIT_BUS] == $past(CMD_BUS_B))
      else $error("word count or bus side not copied");

endmodule

// file: rtl/rmrw_pkg.sv
// Constants, bit layout and state codes of the receive record writer.
// Assumes a 16-bit shared RAM with a 15-bit word address and one write per cycle.
//
// Summary of operation
// - Each receive record puts the info word at the data pointer, the time tag next, then data.
// - On a message error with deferred data on, only the info word and time tag are stored; immediate mode keeps the words written before the error.
// - With deferred data on, data words go to RAM after the message, else as each arrives.
// - Bit 15 flags an RT-RT receive whose sender did not start before the response time-out.
// - Bit 14 flags a Manchester or parity error in any received data word.
// - Bit 13 shows a gap error when the select bit is 0 and broadcast when it is 1.
// - Bit 12 flags fewer contiguous data words than the command word count.
// - Bit 11 flags a data word that came with a command/status sync.
// - Bit 10 summarises the errors of bits 7 and 11 to 15.
// - Bit 9 flags a BUSY answer from global or per-command busy, data still stored.
// - Bit 8 copies the illegal-command table entry of the received command.
// - Bit 7 flags a bad second command word or a bad or misaddressed sender status.
// - Bit 6 flags an RT-RT receive that ended without any error.
// - Bit 5 is 0 for bus A and 1 for bus B.
// - Bits 4 to 0 copy the command word count, where zero means 32 words.

package rmrw_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int unsigned ADDR_W    = 15;
   localparam int unsigned DATA_W    = 16;
   localparam int unsigned WC_W      = 5;
   localparam int unsigned CNT_W     = 6;
   localparam int unsigned BUF_AW    = 5;
   localparam int unsigned BUF_DEPTH = 32;

   ////////////////////////////////////////////////////////////////////////////////
   // Counts, offsets and reset values
   localparam logic [CNT_W-1:0]  FULL_COUNT  = 6'h20;
   localparam logic [CNT_W-1:0]  CNT_ONE     = 6'h01;
   localparam logic [WC_W-1:0]   WC_ZERO     = 5'h00;
   localparam logic [ADDR_W-1:0] TAG_OFFSET  = 15'h0001;
   localparam logic [ADDR_W-1:0] DATA_OFFSET = 15'h0002;
   localparam logic [DATA_W-1:0] INFO_RESET  = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Info word bit positions
   localparam int unsigned BIT_TIMEOUT = 15;
   localparam int unsigned BIT_BADWORD = 14;
   localparam int unsigned BIT_GAPBC   = 13;
   localparam int unsigned BIT_SHORT   = 12;
   localparam int unsigned BIT_SYNC    = 11;
   localparam int unsigned BIT_MESSAGE_ERROR_FLAG    = 10;
   localparam int unsigned BIT_BUSY    = 9;
   localparam int unsigned BIT_ILLEGAL = 8;
   localparam int unsigned BIT_SENDER  = 7;
   localparam int unsigned BIT_TERMINAL_TO_TERMINAL_FLAG    = 6;
   localparam int unsigned BIT_BUS     = 5;
   localparam int unsigned BIT_WC_MSB  = 4;
   localparam int unsigned BIT_WC_LSB  = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky error flag indices
   localparam int unsigned FLG_TIMEOUT = 0;
   localparam int unsigned FLG_BADWORD = 1;
   localparam int unsigned FLG_SYNC    = 2;
   localparam int unsigned FLG_GAP     = 3;
   localparam int unsigned FLG_SENDER  = 4;
   localparam int unsigned NUM_FLAGS   = 5;

   ////////////////////////////////////////////////////////////////////////////////
   // Record writer states
   typedef enum logic [2:0] {
      RMRW_IDLE    = 3'b000,
      RMRW_RECEIVE = 3'b001,
      RMRW_CLOSE   = 3'b010,
      RMRW_FLUSH   = 3'b011,
      RMRW_TAG     = 3'b100,
      RMRW_INFO    = 3'b101
   } rmrw_state_e;

endpackage

// file: rtl/rmrw_word_buf.sv
// Holding store for data words of one message while their RAM write is deferred.
// Assumes one write and one read per cycle; read data appear one cycle after the address.
`timescale 1ns/1ps

module rmrw_word_buf (
   // Clock
   input  wire logic                            core_clk,
   // Write side
   input  wire logic                            wr_en,
   input  wire logic [rmrw_pkg::BUF_AW-1:0]     wr_addr,
   input  wire logic [rmrw_pkg::DATA_W-1:0]     wr_data,
   // Read side
   input  wire logic [rmrw_pkg::BUF_AW-1:0]     rd_addr,
   output logic      [rmrw_pkg::DATA_W-1:0]     rd_data
);

   logic [rmrw_pkg::DATA_W-1:0] mem_reg [rmrw_pkg::BUF_DEPTH];

   ////////////////////////////////////////////////////////////////////////////////
   // Storage without reset, contents are only read after being written
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge core_clk) begin
      rd_data <= mem_reg[rd_addr];
   end

endmodule

// file: testbench/rmrw_ram_model.sv
// Shared RAM as the host sees it: one write per cycle, read at any time.
// Assumes the writer's strobe, address and data are settled at the rising edge.
`timescale 1ns/1ps

module rmrw_ram_model (
   // Clock
   input  wire logic                        clk,
   // Write port
   input  wire logic                        wr_en,
   input  wire logic [rmrw_pkg::ADDR_W-1:0] wr_addr,
   input  wire logic [rmrw_pkg::DATA_W-1:0] wr_data,
   // Host read port
   input  wire logic [rmrw_pkg::ADDR_W-1:0] rd_addr,
   output logic      [rmrw_pkg::DATA_W-1:0] rd_data
);
   logic [rmrw_pkg::DATA_W-1:0] mem [0:32767];
   ////////////////////////////////////////////////////////////////////////////////
   // Marker fill, so a suppressed word stands out
   initial begin
      for (int i = 0; i < 32768; i++) begin
         mem[i] = 16'hFFFF;
      end
   end
   // Store every strobe; no back-pressure
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end
   // Host view
   assign rd_data = mem[rd_addr];
endmodule

// file: testbench/rmrw_record_writer_tb_top.sv
// Bench for the record writer: decoder-side stimulus, checks via RAM readback.
// Assumes inputs change at the falling edge and the RAM model sees all writes.
`timescale 1ns/1ps

module rmrw_record_writer_tb_top;
   logic        clk, rst, dfr, sel, cv, bb, bc, rr, il, gb, pb, wv, me, pe, cs, to, gp, sf, md;
   logic        we, busy, done, rx;
   logic [4:0]  wc;
   logic [14:0] ptr, ra, wa;
   logic [15:0] tag, wd, rd, wdat, info;
   int          num_errors, checked, wrs;
   ////////////////////////////////////////////////////////////////////////////////
   // Design and RAM
   rmrw_record_writer rmrw_record_writer_i (.CORE_CLK(clk), .RST(rst),
      .DEFER_DATA_WRITE(dfr), .GAP_OR_BCAST_SELECT(sel), .CMD_VALID(cv), .CMD_WORD_COUNT(wc),
      .CMD_BUS_B(bb), .CMD_BROADCAST(bc), .CMD_RT_RT(rr), .CMD_ILLEGAL(il),
      .CMD_GLOBAL_BUSY(gb), .CMD_PER_COMMAND_BUSY(pb), .CMD_DATA_POINTER(ptr),
      .CMD_TIME_TAG(tag), .WORD_VALID(wv), .WORD_DATA(wd), .WORD_MANCHESTER_ERR(me),
      .WORD_PARITY_ERR(pe), .WORD_CMD_SYNC(cs), .RESP_TIMEOUT(to), .GAP_DETECTED(gp),
      .SENDER_FAULT(sf), .MSG_DONE(md), .RAM_WR_EN(we), .RAM_WR_ADDR(wa), .RAM_WR_DATA(wdat),
      .RECORD_BUSY(busy), .RECORD_DONE(done), .LAST_INFO_WORD(info));
   rmrw_ram_model rmrw_ram_model_i (.clk(clk), .wr_en(we), .wr_addr(wa), .wr_data(wdat),
      .rd_addr(ra), .rd_data(rd));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, and writes seen while the message is still arriving
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // One process owns the write counter; a new command clears it
   always @(posedge clk) begin
      if (cv) wrs <= 0;
      else if (rx && we) wrs <= wrs + 1;
   end
   // Compare and verdict
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (num_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic rdm(input logic [14:0] a, input logic [15:0] exp, input string nm);
      ra = a;
      #1;
      chk(nm, rd, exp);
   endtask
   // One message; ev: 0 busB,1 bcast,2 terminal_to_terminal_flag,3 illegal,4/5 busy,6 tmo,7 gap,8 sender,
   // 9 parity,10 sync,11 manchester (bad qualifiers go on the last word)
   task automatic run(input logic d, s, input logic [4:0] c, input int n,
                      input logic [11:0] ev);
      int          cnt, k;
      logic        m;
      logic [15:0] e;
      cnt = (c == 5'h00) ? 32 : c;
      m = (ev[6] & ev[2]) | ev[11] | ev[9] | ev[10] | ev[8] | ev[7] | (n < cnt);
      e = {ev[6] & ev[2], ev[11] | ev[9], s ? ev[1] : ev[7], n < cnt, ev[10], m,
           ev[4] | ev[5], ev[3], ev[8], ev[2] & !m, ev[0], c};
      @(negedge clk);
      {dfr, sel, wc, pb, gb, il, rr, bc, bb} = {d, s, c, ev[5:0]};
      ptr = ptr + 15'h0040;
      tag = ~{1'b0, ptr};
      cv = 1;
      @(negedge clk);
      cv = 0;
      rx = 1;
      chk("busy", {15'h0000, busy}, 16'h0001);
      for (k = 0; k < n; k++) begin
         {wv, wd} = {1'b1, 16'h4000 + {1'b0, ptr} + 16'(k)};
         {me, pe, cs} = (k == n - 1) ? {ev[11], ev[9], ev[10]} : 3'b000;
         @(negedge clk);
      end
      {wv, me, pe, cs, to, gp, sf} = {4'h0, ev[6], ev[7], ev[8]};
      @(negedge clk);
      {to, gp, sf, md} = 4'b0001;
      @(negedge clk);
      md = 0;
      rx = 0;
      for (k = 0; k < 60 && done !== 1'b1; k++) @(negedge clk);
      chk("done", {15'h0000, done}, 16'h0001);
      chk("last info", info, e);
      // Info write lands in RAM one edge after the done pulse
      @(negedge clk);
      chk("idle", {15'h0000, busy}, 16'h0000);
      rdm(ptr, e, "ram info");
      rdm(ptr + 15'h0001, tag, "ram tag");
      if (d) chk("early writes", 16'(wrs), 16'h0000);
      else if (!m) chk("live writes", 16'(wrs), 16'(n));
      if (!m) begin
         for (k = 0; k < n; k++) begin
            rdm(ptr + 15'h0002 + 15'(k), 16'h4000 + {1'b0, ptr} + 16'(k), "data");
         end
      end else if (d) begin
         rdm(ptr + 15'h0002, 16'hFFFF, "suppressed");
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rst, dfr, sel, cv, bb, bc, rr, il, gb, pb, wv, me, pe, cs, to, gp, sf, md, rx} = '0;
      {wc, ra, tag, wd} = '0;
      ptr = 15'h04C0;
      num_errors = 0;
      checked = 0;
      rst = 1;
      repeat (4) @(negedge clk);
      rst = 0;
      chk("reset info", info, 16'h0000);
      run(0, 0, 5'h03, 3, 12'h001);
      run(1, 0, 5'h02, 2, 12'h004);
      run(1, 0, 5'h03, 2, 12'h000);
      run(0, 0, 5'h02, 2, 12'h800);
      run(0, 0, 5'h02, 2, 12'h200);
      run(0, 0, 5'h02, 2, 12'h400);
      run(0, 0, 5'h01, 1, 12'h080);
      run(0, 1, 5'h01, 1, 12'h002);
      run(1, 0, 5'h01, 1, 12'h044);
      run(0, 0, 5'h01, 1, 12'h040);
      run(0, 0, 5'h01, 1, 12'h010);
      run(1, 0, 5'h01, 1, 12'h020);
      run(0, 0, 5'h01, 1, 12'h008);
      run(0, 0, 5'h01, 1, 12'h104);
      run(1, 0, 5'h00, 32, 12'h000);
      report_and_stop();
   end
   // Watchdog at 10000 cycles, well past the few hundred cycles the tests need
   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end
endmodule
